/* File: hw/dlu_bank.v */
// input and dac register banks with parallel copy and registered readback
`timescale 1ns/10ps
`include "dlu_map.vh"
module dlu_bank (
    input  wire                      clk_in,
    input  wire                      sys_rst_in,
    input  wire                      wr_en_in,
    input  wire [`DLU_CH_W-1:0]      wr_ch_in,
    input  wire [`DLU_DATA_W-1:0]    wr_data_in,
    input  wire [`DLU_NUM_CH-1:0]    load_in,
    input  wire                      clear_in,
    input  wire [`DLU_CH_W-1:0]      rd_ch_in,
    output reg  [`DLU_DATA_W-1:0]    rd_data_out
);
    // words kept per channel so that each register has a single driving process
    wire [`DLU_NUM_CH*`DLU_DATA_W-1:0] dac_flat;

    genvar g;
    generate
        for (g = 0; g < `DLU_NUM_CH; g = g + 1) begin : g_ch
            reg  [`DLU_DATA_W-1:0] in_word_reg;
            reg  [`DLU_DATA_W-1:0] dac_word_reg;
            wire                   hit = wr_en_in
                                         && ({{(32-`DLU_CH_W){1'b0}}, wr_ch_in} == g);
            always @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    in_word_reg  <= `DLU_DATA_ZERO;
                    dac_word_reg <= `DLU_DATA_ZERO;
                end else if (clear_in) begin
                    in_word_reg  <= `DLU_DATA_ZERO;
                    dac_word_reg <= `DLU_DATA_ZERO;
                end else begin
                    if (hit)
                        in_word_reg <= wr_data_in;
                    // a copy in the write cycle takes the fresh word, not the stale one
                    if (load_in[g])
                        dac_word_reg <= hit ? wr_data_in : in_word_reg;
                end
            end
            assign dac_flat[g*`DLU_DATA_W +: `DLU_DATA_W] = dac_word_reg;
        end
    endgenerate

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            rd_data_out <= `DLU_DATA_ZERO;
        else
            rd_data_out <= dac_flat[rd_ch_in*`DLU_DATA_W +: `DLU_DATA_W];
    end
endmodule // dlu_bank

/* File: hw/dlu_map.vh */
// constants for the dac load/update control block
`ifndef DLU_MAP_VH
`define DLU_MAP_VH

// clock and power-on reset timing
`define DLU_CLK_PERIOD_NS  10
`define DLU_POR_TIME_NS    1000
`define DLU_POR_CNT_W      8

// serial frame layout
`define DLU_FRAME_BITS     6'd32
`define DLU_FRAME_LAST     6'd31
`define DLU_BIT_CNT_W      6
`define DLU_SHIFT_W        32
`define DLU_SHIFT_ZERO     32'h00000000
`define DLU_CMD_HI         27
`define DLU_CMD_LO         24
`define DLU_ADDR_HI        23
`define DLU_ADDR_LO        20
`define DLU_DATA_HI        19
`define DLU_DATA_LO        4
`define DLU_CHSEL_HI       7
`define DLU_CHSEL_LO       0
`define DLU_PDMODE_HI      9
`define DLU_PDMODE_LO      8

// command_code_bits values
`define DLU_CMD_WRITE_N        4'h0
`define DLU_CMD_UPDATE_N       4'h1
`define DLU_CMD_WRITE_UPD_ALL  4'h3
`define DLU_CMD_POWER          4'h4
`define DLU_CMD_LOAD_MASK      4'h6

// widths and reset values
`define DLU_NUM_CH         8
`define DLU_DATA_W         16
`define DLU_CH_W           3
`define DLU_MASK_RESET     8'h00
`define DLU_PD_RESET       8'h00
`define DLU_PDMODE_NORMAL  2'h0
`define DLU_ALL_CH         8'hff
`define DLU_NO_CH          8'h00
`define DLU_DATA_ZERO      16'h0000

// synchronised pin positions
`define DLU_PIN_SYNC       0
`define DLU_PIN_SCLK       1
`define DLU_PIN_SDIN       2
`define DLU_PIN_STROBE     3
`define DLU_PIN_CLEAR      4
`define DLU_PIN_W          5
`define DLU_PIN_IDLE       5'h1b

`endif

/* File: hw/dlu_top.v */
// dac load/update control: serial frame decode, load strobe and load-select mask
//
// How it works
// RULE1: sync mode updates on 32nd falling edge
// RULE2: host holds strobe low or pulses it
// RULE3: async write leaves dac register untouched
// RULE4: strobe falling copies pin-controlled channels
// RULE5: command 0011 writes then updates all
// RULE6: mask bit 0 follows the strobe pin
// RULE7: mask bit 1 updates on new data
// RULE8: command 0110 loads mask from DB7..DB0
// RULE9: mask resets to all zeros
// RULE10: host sends mask command as 32-bit frame
// RULE11: strobe and clear ignored during power-on reset
// RULE12: power-up shows input if strobe low
// RULE13: other commands leave mask unchanged
`timescale 1ns/10ps
`include "dlu_map.vh"
module dlu_top (
    input  wire                      clk_in,
    input  wire                      sys_rst_in,
    input  wire                      sync_n_in,
    input  wire                      sclk_in,
    input  wire                      sdin_in,
    input  wire                      load_strobe_n_in,
    input  wire                      clear_pin_n_in,
    input  wire [`DLU_CH_W-1:0]      rd_ch_in,
    output wire [`DLU_DATA_W-1:0]    dac_rd_data_out,
    output reg  [`DLU_NUM_CH-1:0]    load_mask_out,
    output reg  [`DLU_NUM_CH-1:0]    power_down_out,
    output reg  [1:0]                pd_mode_out,
    output reg  [`DLU_NUM_CH-1:0]    update_out,
    output reg                       frame_done_out,
    output reg                       por_busy_out
);
    localparam POR_CYCLES_I = (`DLU_POR_TIME_NS + `DLU_CLK_PERIOD_NS - 1) / `DLU_CLK_PERIOD_NS;
    localparam [`DLU_POR_CNT_W-1:0] POR_CYCLES = POR_CYCLES_I[`DLU_POR_CNT_W-1:0];

    // one-hot channel select, zero for addresses beyond the last channel
    function [`DLU_NUM_CH-1:0] chan_onehot;
        input [3:0] addr;
        begin
            if (addr < `DLU_NUM_CH)
                chan_onehot = {{(`DLU_NUM_CH-1){1'b0}}, 1'b1} << addr[`DLU_CH_W-1:0];
            else
                chan_onehot = `DLU_NO_CH;
        end
    endfunction

    // two-stage synchronisers for every pin; pin_meta_reg feeds pin_sync_reg only
    reg [`DLU_PIN_W-1:0]      pin_meta_reg;
    reg [`DLU_PIN_W-1:0]      pin_sync_reg;
    reg [`DLU_PIN_W-1:0]      pin_prev_reg;
    wire [`DLU_PIN_W-1:0]     pin_in = {clear_pin_n_in, load_strobe_n_in, sdin_in,
                                        sclk_in, sync_n_in};

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_meta_reg <= `DLU_PIN_IDLE;
            pin_sync_reg <= `DLU_PIN_IDLE;
            pin_prev_reg <= `DLU_PIN_IDLE;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // power-on reset window
    reg [`DLU_POR_CNT_W-1:0] por_cnt_reg;
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            por_cnt_reg  <= {`DLU_POR_CNT_W{1'b0}};
            por_busy_out <= 1'b1;
        end else if (por_busy_out) begin
            por_cnt_reg  <= por_cnt_reg + {{(`DLU_POR_CNT_W-1){1'b0}}, 1'b1};
            por_busy_out <= (por_cnt_reg != POR_CYCLES - {{(`DLU_POR_CNT_W-1){1'b0}}, 1'b1});
        end
    end

    wire frame_active = ~pin_sync_reg[`DLU_PIN_SYNC];
    wire frame_start  = pin_prev_reg[`DLU_PIN_SYNC] & ~pin_sync_reg[`DLU_PIN_SYNC];
    wire sclk_fall    = pin_prev_reg[`DLU_PIN_SCLK] & ~pin_sync_reg[`DLU_PIN_SCLK];
    wire sdin_bit     = pin_sync_reg[`DLU_PIN_SDIN];
    // strobe and clear pins are dead while power-on reset runs; strobe then reads as high
    wire strobe_fall  = ~por_busy_out & pin_prev_reg[`DLU_PIN_STROBE]
                        & ~pin_sync_reg[`DLU_PIN_STROBE];                     // [RULE11]
    wire strobe_low   = ~por_busy_out & ~pin_sync_reg[`DLU_PIN_STROBE];        // [RULE11]
    wire clear_fall   = ~por_busy_out & pin_prev_reg[`DLU_PIN_CLEAR]
                        & ~pin_sync_reg[`DLU_PIN_CLEAR];                      // [RULE11]

    // frame shifter
    reg [`DLU_SHIFT_W-1:0]   shift_reg;
    reg [`DLU_BIT_CNT_W-1:0] bit_cnt_reg;
    reg                      abort_reg;
    reg                      done_reg;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_reg   <= `DLU_SHIFT_ZERO;
            bit_cnt_reg <= {`DLU_BIT_CNT_W{1'b0}};
            abort_reg   <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (clear_fall) begin
                // a clear in mid-frame throws the frame away
                abort_reg <= 1'b1;
            end else if (frame_start) begin
                bit_cnt_reg <= {`DLU_BIT_CNT_W{1'b0}};
                abort_reg   <= 1'b0;
            end else if (sclk_fall && frame_active && !abort_reg
                         && bit_cnt_reg != `DLU_FRAME_BITS) begin
                shift_reg   <= {shift_reg[`DLU_SHIFT_W-2:0], sdin_bit};
                bit_cnt_reg <= bit_cnt_reg + {{(`DLU_BIT_CNT_W-1){1'b0}}, 1'b1};
                if (bit_cnt_reg == `DLU_FRAME_LAST)
                    done_reg <= 1'b1;                                          // [RULE1]
            end
        end
    end

    // frame decode
    wire [3:0]                cmd_code  = shift_reg[`DLU_CMD_HI:`DLU_CMD_LO];
    wire [3:0]                ch_addr   = shift_reg[`DLU_ADDR_HI:`DLU_ADDR_LO];
    wire [`DLU_DATA_W-1:0]    frame_dat = shift_reg[`DLU_DATA_HI:`DLU_DATA_LO];
    wire [`DLU_NUM_CH-1:0]    frame_sel = shift_reg[`DLU_CHSEL_HI:`DLU_CHSEL_LO];
    wire [1:0]                frame_pdm = shift_reg[`DLU_PDMODE_HI:`DLU_PDMODE_LO];
    wire [`DLU_NUM_CH-1:0]    addr_sel  = chan_onehot(ch_addr);

    reg                       wr_en;
    reg [`DLU_NUM_CH-1:0]     load_vec;
    reg [`DLU_NUM_CH-1:0]     mask_next;
    reg [`DLU_NUM_CH-1:0]     pd_next;
    reg [1:0]                 pdm_next;

    always @* begin
        wr_en     = 1'b0;
        mask_next = load_mask_out;
        pd_next   = power_down_out;
        pdm_next  = pd_mode_out;
        // pin-controlled channels copy on the strobe's falling edge
        load_vec  = strobe_fall ? ~load_mask_out : `DLU_NO_CH;               // [RULE4] [RULE6]
        if (done_reg) begin
            case (cmd_code)
                `DLU_CMD_WRITE_N: begin
                    wr_en = (addr_sel != `DLU_NO_CH);
                    // strobe low or mask bit set: update now, else hold the dac register
                    load_vec = load_vec | (addr_sel & (load_mask_out
                               | (strobe_low ? `DLU_ALL_CH : `DLU_NO_CH))); // [RULE1] [RULE3] [RULE7]
                end
                `DLU_CMD_UPDATE_N: begin
                    load_vec = load_vec | addr_sel;
                end
                `DLU_CMD_WRITE_UPD_ALL: begin
                    wr_en    = (addr_sel != `DLU_NO_CH);
                    load_vec = `DLU_ALL_CH;                                    // [RULE5]
                end
                `DLU_CMD_LOAD_MASK: begin
                    mask_next = frame_sel;                                     // [RULE8]
                end
                `DLU_CMD_POWER: begin
                    pdm_next = frame_pdm;
                    if (frame_pdm == `DLU_PDMODE_NORMAL) begin
                        pd_next = power_down_out & ~frame_sel;
                        // waking with strobe low shows the input register
                        if (strobe_low)
                            load_vec = load_vec | (power_down_out & frame_sel); // [RULE12]
                    end else begin
                        pd_next = power_down_out | frame_sel;
                    end
                end
                default: begin
                    mask_next = load_mask_out;                                 // [RULE13]
                end
            endcase
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            load_mask_out  <= `DLU_MASK_RESET;                                 // [RULE9]
            power_down_out <= `DLU_PD_RESET;
            pd_mode_out    <= `DLU_PDMODE_NORMAL;
            update_out     <= `DLU_NO_CH;
            frame_done_out <= 1'b0;
        end else begin
            load_mask_out  <= mask_next;
            power_down_out <= pd_next;
            pd_mode_out    <= pdm_next;
            update_out     <= clear_fall ? `DLU_NO_CH : load_vec;
            frame_done_out <= done_reg;
        end
    end

    dlu_bank u_bank (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (wr_en & ~clear_fall),
        .wr_ch_in    (ch_addr[`DLU_CH_W-1:0]),
        .wr_data_in  (frame_dat),
        .load_in     (clear_fall ? `DLU_NO_CH : load_vec),
        .clear_in    (clear_fall),
        .rd_ch_in    (rd_ch_in),
        .rd_data_out (dac_rd_data_out)
    );
endmodule // dlu_top

/* File: tb/dlu_host.sv */
// host controller model: serial frames and the load strobe pin
`timescale 1ns/10ps
module dlu_host (
    input  wire logic clk_in,
    output logic      sync_n_out,
    output logic      sclk_out,
    output logic      sdin_out,
    output logic      strobe_n_out,
    output logic      clear_n_out
);
    initial begin
        clear_n_out = 1'b1;
        sync_n_out = 1'b1;
        sclk_out = 1'b1;
        sdin_out = 1'b0;
        strobe_n_out = 1'b1;
    end
    // whole 32-bit frame msb first, sclk parked high outside frames
    task automatic send_frame(input logic [31:0] frame, input int half);
        @(posedge clk_in) sync_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int i = 31; i >= 0; i--) begin
            sdin_out <= frame[i];
            repeat (half) @(posedge clk_in);
            sclk_out <= 1'b0;
            repeat (half) @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        sync_n_out <= 1'b1;
        // data line released with no pull: show the inverse, not a stale bit
        sdin_out <= ~frame[0];
        repeat (4) @(posedge clk_in);
    endtask
    // held low for sync mode or pulsed for async
    task automatic set_strobe(input logic lvl);
        @(posedge clk_in) strobe_n_out <= lvl;
        repeat (4) @(posedge clk_in);
    endtask
    // clear pin is falling-edge active
    task automatic set_clear(input logic lvl);
        @(posedge clk_in) clear_n_out <= lvl;
        repeat (4) @(posedge clk_in);
    endtask
endmodule // dlu_host

/* File: tb/dlu_top_assertions.sv */
// concurrent checks on the ports of the dac load/update control top
`timescale 1ns/10ps
module dlu_top_assertions (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       load_strobe_n_in,
    input wire logic [7:0] load_mask_out,
    input wire logic [7:0] update_out,
    input wire logic       frame_done_out,
    input wire logic       por_busy_out
);
    int por_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) por_cnt <= 0;
        else if (por_busy_out) por_cnt <= por_cnt + 1;
    end
    a_mask_reset: assert property ($fell(sys_rst_in) |-> load_mask_out == 8'h00)
        else $error("mask not clear after reset");
    a_mask_change: assert property ($changed(load_mask_out) |->
        ($past(frame_done_out) or ##[0:1] frame_done_out)) else $error("mask moved off frame");
    a_por_quiet: assert property (por_busy_out && !frame_done_out |-> update_out == 8'h00)
        else $error("strobe acted during power-on window");
    a_por_length: assert property ($fell(por_busy_out) |-> por_cnt inside {[99:101]})
        else $error("power-on window length wrong");
    a_update_pulse: assert property (update_out != 8'h00 |=> update_out == 8'h00)
        else $error("update pulse longer than one cycle");
    a_done_pulse: assert property (frame_done_out |=> !frame_done_out)
        else $error("frame done longer than one cycle");
    a_strobe_mask: assert property (update_out != 8'h00 && !frame_done_out
        |-> update_out == ~load_mask_out) else $error("strobe update ignores mask");
    a_strobe_resp: assert property ($fell(load_strobe_n_in) && !por_busy_out
        |-> ##[2:6] update_out == ~load_mask_out) else $error("no update after strobe");
    c_strobe: cover property (update_out != 8'h00 && !frame_done_out);
    c_all: cover property (frame_done_out && update_out == 8'hff);
    c_mask: cover property ($changed(load_mask_out));
endmodule // dlu_top_assertions

/* File: tb/tb_dlu_top.sv */
// self-checking bench for the dac load/update control top
`timescale 1ns/10ps
module tb_dlu_top;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  rd_ch_in = 3'h0;
    logic        sync_n, sclk, sdin, strobe_n, clr_n, done_seen, clr = 1'b1;
    logic [15:0] dac_rd_data_out;
    logic [7:0]  load_mask_out, update_out, power_down_out, seen, mask = 8'h00, pd = 8'h00;
    logic [1:0]  pd_mode_out, pdm = 2'h0;
    logic        frame_done_out, por_busy_out;
    logic [15:0] in_reg[8], dac_reg[8];
    logic [31:0] seed = 32'd62392;
    int          n_errors = 0, n_tests = 0;
    dlu_host dlu_host_inst (.clk_in(clk_in), .sync_n_out(sync_n), .sclk_out(sclk),
        .sdin_out(sdin), .strobe_n_out(strobe_n), .clear_n_out(clr_n));
    dlu_top dlu_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sync_n_in(sync_n),
        .sclk_in(sclk), .sdin_in(sdin), .load_strobe_n_in(strobe_n), .clear_pin_n_in(clr_n),
        .rd_ch_in(rd_ch_in), .dac_rd_data_out(dac_rd_data_out), .load_mask_out(load_mask_out),
        .power_down_out(power_down_out), .pd_mode_out(pd_mode_out), .update_out(update_out),
        .frame_done_out(frame_done_out), .por_busy_out(por_busy_out));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) seen <= clr ? 8'h00 : (seen | update_out);
    always @(posedge clk_in) done_seen <= clr ? 1'b0 : (done_seen | frame_done_out);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask
    task automatic check_all(input logic [7:0] exp_upd, input logic exp_done);
        repeat (10) @(posedge clk_in);
        #1 chk8(seen, exp_upd);
        chk8({7'h00, done_seen}, {7'h00, exp_done});
        chk8(load_mask_out, mask);
        chk8(power_down_out, pd);
        chk8({6'h00, pd_mode_out}, {6'h00, pdm});
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_in) rd_ch_in <= c[2:0];
            repeat (2) @(posedge clk_in);
            #1 chk(dac_rd_data_out, dac_reg[c]);
        end
        @(posedge clk_in) clr <= 1'b1;
        @(posedge clk_in) clr <= 1'b0;
    endtask
    task automatic apply(input logic [7:0] up);
        for (int c = 0; c < 8; c++)
            if (up[c]) dac_reg[c] = in_reg[c];
    endtask
    task automatic frame(input logic [3:0] cmd, input logic [2:0] ch, input int half);
        logic [31:0] r, f;
        logic [15:0] d;
        logic [7:0]  up;
        r = rnd();
        d = 16'(rnd());
        f = {r[31:28], cmd, 1'b0, ch, d, r[3:0]};
        // power frames take their mode from the channel field, so both modes occur
        if (cmd == 4'h4) f[9:8] = ch[1:0];
        up = 8'h00;
        case (cmd)
            4'h0: begin
                in_reg[ch] = d;
                up[ch] = !strobe_n || mask[ch];
            end
            4'h1: up[ch] = 1'b1;
            4'h3: begin
                in_reg[ch] = d;
                up = 8'hff;
            end
            4'h4: begin
                pdm = f[9:8];
                if (f[9:8] == 2'h0) begin
                    if (!strobe_n) up = pd & f[7:0];
                    pd = pd & ~f[7:0];
                end else begin
                    pd = pd | f[7:0];
                end
            end
            4'h6: mask = f[7:0];
            default: up = 8'h00;
        endcase
        apply(up);
        dlu_host_inst.send_frame(f, half);
        check_all(up, 1'b1);
    endtask
    task automatic strobe(input logic lvl);
        logic [7:0] up;
        up = (!lvl && strobe_n) ? ~mask : 8'h00;
        apply(up);
        dlu_host_inst.set_strobe(lvl);
        check_all(up, 1'b0);
    endtask
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset, then strobe and clear wiggled inside the power-on window
    task automatic power_on();
        for (int c = 0; c < 8; c++) begin
            in_reg[c] = 16'h0000;
            dac_reg[c] = 16'h0000;
        end
        mask = 8'h00;
        pd = 8'h00;
        pdm = 2'h0;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        clr <= 1'b0;
        dlu_host_inst.set_strobe(1'b0);
        dlu_host_inst.set_clear(1'b0);
        dlu_host_inst.set_clear(1'b1);
        dlu_host_inst.set_strobe(1'b1);
        for (int i = 0; i < 200 && por_busy_out !== 1'b0; i++) @(posedge clk_in);
        chk({15'h0000, por_busy_out}, 16'h0000);
        check_all(8'h00, 1'b0);
    endtask
    initial begin
        power_on();
        frame(4'h0, 3'h2, 4);
        frame(4'h9, 3'h5, 4);
        strobe(1'b0);
        frame(4'h0, 3'h7, 4);
        strobe(1'b1);
        for (int k = 0; k < 4; k++) begin
            frame(4'h6, 3'h0, 4);
            frame(4'h0, 3'(k), 4);
            frame(4'h0, 3'(k + 4), 4);
            frame(4'h1, 3'(k), 4);
            frame(4'h4, 3'h1, 4);
            strobe(1'b0);
            frame(4'h4, 3'h0, 4);
            strobe(1'b1);
            frame(4'h4, 3'h4, 4);
            frame(4'h3, 3'(k * 2), 4);
        end
        // clear after the power-on window zeros both register banks
        for (int c = 0; c < 8; c++) begin
            in_reg[c] = 16'h0000;
            dac_reg[c] = 16'h0000;
        end
        dlu_host_inst.set_clear(1'b0);
        check_all(8'h00, 1'b0);
        dlu_host_inst.set_clear(1'b1);
        sys_rst_in <= 1'b1;
        power_on();
        summarize();
    end
    // about 35 frames of some 3 us each and two power-on windows, with generous slack
    initial begin
        #400us;
        n_errors++;
        summarize();
    end
endmodule // tb_dlu_top
bind dlu_top dlu_top_assertions dlu_top_assertions_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .load_strobe_n_in(load_strobe_n_in),
    .load_mask_out(load_mask_out), .update_out(update_out),
    .frame_done_out(frame_done_out), .por_busy_out(por_busy_out));
